/* File: hw/pin_switch_matrix.v */
// Purpose: Switch matrix routing peripheral signals to port pins, with an
//          APB register slave holding the routing configuration.
// Assumes: Pad level arrives on pin_in; peripherals give value and enable.
// Notes:   Routing paths are combinational from the configuration flops.
//
// Operation
// - Every movable function owns one 8-bit field holding its pin number.
// - Assignable pins are indices 0 to 5 and 7 to 17; 6 is absent.
// - One pin may feed all input functions programmed with its number.
// - An output sharing a pin with inputs drives them too: loopback.
// - A routed output function enables the pad driver under its control.
// - Any function assigned to a pin disables its port output path.
// - Analog fixed function connects analog path, pad digital off.
// - Pin digital level reaches port input and match logic, which read 0 on pins with an analog function selected; pin status still shows their level.
// - One select bit per fixed function attaches or detaches it.
// - A deselected fixed function frees its pin for movable functions.
// - A pin with nothing assigned returns to its port function.
// - Reset clears all fixed selects except the reset pin select.
// - Sync clocks, SPI, I2C bidirectional; transmit, match etc output.
// - All-ones pin field means unconnected; writing it disconnects.
// - Routing needs no clock; clock only serves register access.
// - Every reset source returns all configuration to defaults.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "pin_switch_regs.vh"

module pin_switch_matrix #(
  parameter NUM_PINS = `NUM_PINS,
  parameter NUM_MOVABLE = `NUM_MOVABLE,
  parameter NUM_FIXED = `NUM_FIXED
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NUM_PINS-1:0] pin_in,
  output reg [NUM_PINS-1:0] pad_out,
  output reg [NUM_PINS-1:0] pad_oe,
  output reg [NUM_PINS-1:0] pad_digital_en,
  input wire [NUM_PINS-1:0] gpio_out,
  input wire [NUM_PINS-1:0] gpio_oe,
  output reg [NUM_PINS-1:0] gpio_in_level,
  input wire [NUM_MOVABLE-1:0] func_out,
  input wire [NUM_MOVABLE-1:0] func_oe,
  output reg [NUM_MOVABLE-1:0] func_in,
  input wire [NUM_FIXED-1:0] fixed_out,
  input wire [NUM_FIXED-1:0] fixed_oe,
  output reg [NUM_FIXED-1:0] fixed_in,
  output reg [NUM_FIXED-1:0] fixed_analog_en
);

  localparam [NUM_MOVABLE-1:0] DRIVES = `MOVABLE_DRIVES;
  localparam [NUM_MOVABLE-1:0] INPUTS = `MOVABLE_INPUTS;
  localparam [5*NUM_FIXED-1:0] FIX_PINS = `FIXED_PIN_LIST;
  localparam [NUM_FIXED-1:0] FIX_ANALOG = `FIXED_ANALOG;
  localparam [NUM_FIXED-1:0] FIX_DRIVES = `FIXED_DRIVES;
  localparam [NUM_FIXED-1:0] FIX_INPUTS = `FIXED_INPUTS;

  // Pin field names an existing pin
  function valid_pin;
    input [7:0] fld;
    begin
      valid_pin = (fld <= `LAST_PIN_INDEX) &&
                  (fld != `MISSING_PIN_INDEX);
    end
  endfunction

  // ========================================================================
  // Configuration registers
  reg [7:0] field_q [0:NUM_MOVABLE-1];
  reg [NUM_FIXED-1:0] fixed_sel_q;
  reg [NUM_PINS-1:0] pin_meta_q;
  reg [NUM_PINS-1:0] pin_sync_q;

  wire setup_ok = psel & penable & ~pready;
  wire commit = psel & penable & pready;
  wire is_route = (paddr[11:2] <= `ROUTE_LAST_OFFS >> 2) &&
                  (paddr[11:5] == 7'h00);
  wire [2:0] route_idx = paddr[4:2];

  integer f;
  integer b;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (f = 0; f < NUM_MOVABLE; f = f + 1) begin
        field_q[f] <= `FIELD_UNCONNECTED;
      end
      fixed_sel_q <= `FIXED_SEL_RESET;
    end else if (commit && pwrite && !pslverr) begin
      if (is_route) begin
        for (b = 0; b < 4; b = b + 1) begin
          if (pstrb[b] && (route_idx * 4 + b) < NUM_MOVABLE) begin
            field_q[route_idx * 4 + b] <= pwdata[8*b +: 8];
          end
        end
      end else if (paddr == `FIXED_SEL_OFFS && pstrb[0]) begin
        fixed_sel_q <= pwdata[NUM_FIXED-1:0];
      end
    end
  end

  // Pin levels seen by software pass two flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= {NUM_PINS{1'b0}};
      pin_sync_q <= {NUM_PINS{1'b0}};
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ========================================================================
  // APB read data and answer
  reg [31:0] rd_d;
  reg err_d;
  integer r;

  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    if (is_route) begin
      for (r = 0; r < 4; r = r + 1) begin
        if ((route_idx * 4 + r) < NUM_MOVABLE) begin
          rd_d[8*r +: 8] = field_q[route_idx * 4 + r];
        end else begin
          rd_d[8*r +: 8] = `FIELD_UNCONNECTED;
        end
      end
    end else if (paddr == `ROUTE_RSVD_OFFS) begin
      rd_d = `RSVD_READ_VALUE;
    end else if (paddr == `FIXED_SEL_OFFS) begin
      rd_d[NUM_FIXED-1:0] = fixed_sel_q;
    end else if (paddr == `PIN_STATUS_OFFS) begin
      rd_d[NUM_PINS-1:0] = pin_sync_q;
    end else begin
      err_d = 1'b1;
    end
  end

  // One wait cycle: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_ok;
      pslverr <= setup_ok & err_d;
      if (setup_ok && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // ========================================================================
  // Routing, combinational from configuration
  reg [NUM_PINS-1:0] analog_pin;
  reg [NUM_PINS-1:0] fixdig_pin;
  reg [NUM_PINS-1:0] assigned_pin;
  reg [NUM_PINS-1:0] owner_found;
  reg [NUM_PINS-1:0] owner_val;
  reg [NUM_PINS-1:0] owner_oe;
  reg [NUM_PINS-1:0] level;
  integer k;
  integer m;
  integer p;
  integer idx;

  always @* begin
    analog_pin = {NUM_PINS{1'b0}};
    fixdig_pin = {NUM_PINS{1'b0}};
    assigned_pin = {NUM_PINS{1'b0}};
    owner_found = {NUM_PINS{1'b0}};
    owner_val = {NUM_PINS{1'b0}};
    owner_oe = {NUM_PINS{1'b0}};
    level = {NUM_PINS{1'b0}};
    pad_out = {NUM_PINS{1'b0}};
    pad_oe = {NUM_PINS{1'b0}};
    pad_digital_en = {NUM_PINS{1'b0}};
    gpio_in_level = {NUM_PINS{1'b0}};
    func_in = {NUM_MOVABLE{1'b0}};
    fixed_in = {NUM_FIXED{1'b0}};
    fixed_analog_en = {NUM_FIXED{1'b0}};
    // Fixed functions take the pin ahead of movable ones
    for (k = 0; k < NUM_FIXED; k = k + 1) begin
      idx = FIX_PINS[5*k +: 5];
      if (fixed_sel_q[k]) begin
        if (FIX_ANALOG[k]) begin
          analog_pin[idx] = 1'b1;
          fixed_analog_en[k] = 1'b1;
        end else begin
          fixdig_pin[idx] = 1'b1;
          if (FIX_DRIVES[k] && !owner_found[idx]) begin
            owner_found[idx] = 1'b1;
            owner_val[idx] = fixed_out[k];
            owner_oe[idx] = fixed_oe[k];
          end
        end
      end
    end
    for (m = 0; m < NUM_MOVABLE; m = m + 1) begin
      if (valid_pin(field_q[m])) begin
        idx = field_q[m][4:0];
        assigned_pin[idx] = 1'b1;
        if (DRIVES[m] && !owner_found[idx]) begin
          owner_found[idx] = 1'b1;
          owner_val[idx] = func_out[m];
          owner_oe[idx] = func_oe[m];
        end
      end
    end
    for (p = 0; p < NUM_PINS; p = p + 1) begin
      if (p != `MISSING_PIN_INDEX && !analog_pin[p]) begin
        pad_digital_en[p] = 1'b1;
        if (owner_found[p]) begin
          pad_oe[p] = owner_oe[p];
          pad_out[p] = owner_val[p];
          level[p] = owner_oe[p] ? owner_val[p] : pin_in[p];
        end else begin
          level[p] = pin_in[p];
          if (!fixdig_pin[p] && !assigned_pin[p]) begin
            pad_oe[p] = gpio_oe[p];
            pad_out[p] = gpio_out[p];
          end
        end
      end
    end
    gpio_in_level = level;
    for (m = 0; m < NUM_MOVABLE; m = m + 1) begin
      idx = field_q[m][4:0];
      if (INPUTS[m] && valid_pin(field_q[m]) && !analog_pin[idx]) begin
        func_in[m] = level[idx];
      end
    end
    for (k = 0; k < NUM_FIXED; k = k + 1) begin
      idx = FIX_PINS[5*k +: 5];
      if (fixed_sel_q[k] && FIX_INPUTS[k] && !analog_pin[idx]) begin
        fixed_in[k] = level[idx];
      end
    end
  end

endmodule // pin_switch_matrix

/* File: hw/pin_switch_regs.vh */
// Purpose: Register offsets, reset values and routing tables of the switch
//          matrix.
// Assumes: APB with 32-bit data, 12-bit byte offsets.
// Notes:   Definitions only.
`ifndef PIN_SWITCH_REGS_VH
`define PIN_SWITCH_REGS_VH

// ==========================================================================
// Register offsets
`define ROUTE_BASE_OFFS 12'h000
`define ROUTE_LAST_OFFS 12'h018
`define ROUTE_RSVD_OFFS 12'h01c
`define FIXED_SEL_OFFS 12'h1c0
`define PIN_STATUS_OFFS 12'h1c4

// ==========================================================================
// Reset values
`define FIELD_UNCONNECTED 8'hff
`define RSVD_READ_VALUE 32'hffffffff
`define FIXED_SEL_RESET 7'h10

// ==========================================================================
// Pin numbering
`define NUM_PINS 18
`define LAST_PIN_INDEX 8'h11
`define MISSING_PIN_INDEX 8'h06

// ==========================================================================
// Movable functions: 25 fields, four to a route register
`define NUM_MOVABLE 25
`define MOVABLE_DRIVES 25'h1ff1fb5
`define MOVABLE_INPUTS 25'h030ffda

// ==========================================================================
// Fixed-pin functions, select bit k
// 0 cmp in A, 1 cmp in B, 2 debug clock, 3 debug data, 4 reset pin,
// 5 external clock input, 6 converter input
`define NUM_FIXED 7
`define FIXED_PIN_LIST {5'h07, 5'h01, 5'h05, 5'h02, 5'h03, 5'h01, 5'h00}
`define FIXED_ANALOG 7'h43
`define FIXED_DRIVES 7'h08
`define FIXED_INPUTS 7'h3c

`endif

/* File: tb/pin_switch_props.sv */
// Purpose: Port assertions for the switch matrix.
// Assumes: Bound to the matrix top, one clock domain.
// Notes: Pin level rules lean on the board model.
`timescale 1ns/1ps
module pin_switch_props #(
  parameter NUM_PINS = 18,
  parameter NUM_FIXED = 7
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [NUM_PINS-1:0] pin_in,
  input wire [NUM_PINS-1:0] pad_oe,
  input wire [NUM_PINS-1:0] pad_digital_en,
  input wire [NUM_PINS-1:0] gpio_in_level,
  input wire [NUM_FIXED-1:0] fixed_analog_en
);
  // ==========
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_RDY_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_READ: assert property (!$stable(prdata) |-> pready && !pwrite)
    else $error("prdata moved outside a read");
  AST_LEVEL_SEEN: assert property (((gpio_in_level ^ pin_in) & pad_digital_en) == 0)
    else $error("port input level differs from pin");
  AST_ANALOG_OE: assert property ((pad_oe & ~pad_digital_en) == 0)
    else $error("driver on with digital pad off");
  AST_ANALOG_PIN: assert property (!(fixed_analog_en[0] && pad_digital_en[0] ||
    fixed_analog_en[1] && pad_digital_en[1] ||
    fixed_analog_en[6] && pad_digital_en[7]))
    else $error("analog pin keeps digital pad");
  AST_NO_PIN6: assert property (!pad_digital_en[6] && !pad_oe[6])
    else $error("absent pin index six active");
endmodule // pin_switch_props

/* File: tb/pad_world.sv */
// Purpose: Board side of the pads.
// Assumes: One outside driver per pin.
// Notes: Outside level yields to the pad driver.
`timescale 1ns/1ps
module pad_world #(
  parameter NUM_PINS = 18
) (
  input wire [NUM_PINS-1:0] pad_out,
  input wire [NUM_PINS-1:0] pad_oe,
  input wire [NUM_PINS-1:0] ext_level,
  output wire [NUM_PINS-1:0] pin_in
);
  // ==========
  // Pin wire
  assign pin_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule // pad_world

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the switch matrix.
// Assumes: APB answers with one wait state.
// Notes: Routing checked after inputs settle.
`timescale 1ns/1ps
module testbench;
  reg pclk, presetn, psel, penable, pwrite, er;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [3:0] pstrb;
  reg [17:0] gpio_out, gpio_oe, ext_level;
  reg [24:0] func_out, func_oe;
  reg [6:0] fixed_out, fixed_oe;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [17:0] pin_in, pad_out, pad_oe, pad_digital_en, gpio_in_level;
  wire [24:0] func_in;
  wire [6:0] fixed_in, fixed_analog_en;
  integer n_mismatch, comparisons;
  // ==========
  // Instances
  pin_switch_matrix pin_switch_matrix_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_digital_en(pad_digital_en), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_in_level(gpio_in_level), .func_out(func_out), .func_oe(func_oe),
    .func_in(func_in), .fixed_out(fixed_out), .fixed_oe(fixed_oe),
    .fixed_in(fixed_in), .fixed_analog_en(fixed_analog_en));
  pad_world pad_world_i (.pad_out(pad_out), .pad_oe(pad_oe),
    .ext_level(ext_level), .pin_in(pin_in));
  always #10 pclk = ~pclk;
  // ==========
  // Tasks
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin @(posedge pclk); i = i + 1; end
      while (pready !== 1'b1 && i < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (i >= 20) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t no pready", $time);
        test_done;
      end
      @(posedge pclk);
    end
  endtask
  task t_reset;
    integer k;
    begin
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (k = 0; k < 8; k = k + 1) begin
        apb(1'b0, {k[9:0], 2'b00}, 32'h0);
        check(rd, 32'hffffffff);
      end
      apb(1'b0, 12'h1c0, 32'h0);
      check(rd, 32'h10);
      apb(1'b0, 12'h100, 32'h0);
      check(er, 1'b1);
      #2 check(pad_oe & ~18'h40, 18'h3ff9f);
      check(pad_out & 18'h3ff9f, 18'h15515);
      @(posedge pclk);
    end
  endtask
  task t_loop;
    begin
      func_oe <= 25'h1; func_out <= 25'h1; ext_level <= 18'h3ffff;
      apb(1'b1, 12'h000, 32'h09ff0909);
      #2 check({pad_oe[9], pad_out[9]}, 2'b11);
      check(func_in & 25'ha, 25'ha);
      @(posedge pclk);
      func_out <= 25'h0;
      #2 check(func_in & 25'ha, 25'h0);
      @(posedge pclk);
      apb(1'b1, 12'h000, 32'h09ff09ff);
      apb(1'b1, 12'h008, 32'hffffff0b);
      #2 check({pad_oe[9], func_in[0], func_in[8]}, 3'b001);
      check(func_in & 25'ha, 25'ha);
      @(posedge pclk);
      func_oe <= 25'h100;
      #2 check({pad_oe[11], pad_out[11]}, 2'b10);
      @(posedge pclk);
    end
  endtask
  task t_invalid;
    integer k;
    reg [7:0] v;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        v = (k == 0) ? 8'h06 : (k == 1) ? 8'h12 : (k == 2) ? 8'hfe : 8'h11;
        apb(1'b1, 12'h000, {16'hffff, v, 8'hff});
        #2 check(func_in[1], k == 3);
        @(posedge pclk);
      end
    end
  endtask
  task t_fixed;
    begin
      apb(1'b1, 12'h000, 32'hffffffff);
      apb(1'b1, 12'h1c0, 32'h1);
      apb(1'b0, 12'h1c0, 32'h0);
      check(rd, 32'h1);
      #2 check({fixed_analog_en, pad_digital_en[0]}, 8'h02);
      check(pad_oe[5], 1'b1);
      @(posedge pclk);
      func_oe <= 25'h5; func_out <= 25'h1; fixed_oe <= 7'h8;
      apb(1'b1, 12'h000, 32'hff0aff0a); // Both outputs on one pin
      #2 check(pad_out[10], 1'b1);
      @(posedge pclk);
      apb(1'b1, 12'h000, 32'hffffff02);
      #2 check({pad_oe[2], pad_out[2]}, 2'b11);
      @(posedge pclk);
      apb(1'b1, 12'h1c0, 32'h8); // Debug data select takes pin 2 from function 0
      #2 check({pad_oe[2], pad_out[2]}, 2'b10);
      check({fixed_in[3], gpio_in_level[2]}, 2'b00);
      @(posedge pclk);
      apb(1'b0, 12'h1c4, 32'h0);
      check(rd, 32'h00015d51);
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hf;
    gpio_out = 18'h15555; gpio_oe = 18'h3ffff; ext_level = 18'h0;
    func_out = 25'h0; func_oe = 25'h0; fixed_out = 7'h0; fixed_oe = 7'h0;
    n_mismatch = 0; comparisons = 0;
    t_reset;
    t_loop;
    t_invalid;
    t_fixed;
    t_reset;
    test_done;
  end
endmodule // testbench
bind pin_switch_matrix pin_switch_props #(.NUM_PINS(NUM_PINS),
  .NUM_FIXED(NUM_FIXED)) pin_switch_props_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pad_oe(pad_oe), .pad_digital_en(pad_digital_en),
  .gpio_in_level(gpio_in_level), .fixed_analog_en(fixed_analog_en));
